/* File: hw/cap_pkg.sv */
// Constants for the hot swap and product data capability items
package cap_pkg;
   localparam logic [7:0]  HS_OFFSET      = 8'he4;
   localparam logic [7:0]  PD_OFFSET      = 8'he8;
   localparam logic [7:0]  DATA_OFFSET    = 8'hec;
   localparam logic [7:0]  HS_CAPABILITY_IDENTIFIER      = 8'h06;
   localparam logic [7:0]  PD_CAPABILITY_IDENTIFIER      = 8'h03;
   localparam logic [7:0]  HS_NEXT_PD     = 8'he8;
   localparam logic [7:0]  NEXT_END       = 8'h00;
   localparam logic [7:0]  ADDR_RESET     = 8'h00;
   localparam logic [31:0] DATA_RESET     = 32'h0000_0000;
   localparam int          INS_BIT        = 23;
   localparam int          EXT_BIT        = 22;
   localparam int          LED_BIT        = 19;
   localparam int          MASK_BIT       = 17;
   localparam int          FLAG_BIT       = 31;
   localparam int          ADDR_LSB       = 16;
   localparam int          NEXT_LSB       = 8;
endpackage

/* File: hw/eeprom_if.sv */
// Request and answer carrier between capability registers and EEPROM port
`timescale 1ns/100ps
interface eeprom_if;
   logic        start;
   logic        write;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        done;
   logic [31:0] rdata;
   modport regs (output start, write, addr, wdata, input done, rdata);
   modport port (input start, write, addr, wdata, output done, rdata);
endinterface

/* File: hw/eeprom_port.sv */
// Passes a 4-byte access to the serial EEPROM engine and returns completion
`timescale 1ns/100ps
module eeprom_port (
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   eeprom_if.port    req,
   output      logic ee_req,
   output      logic ee_write,
   output      logic [7:0]  ee_addr,
   output      logic [31:0] ee_wdata,
   input  wire logic ee_done,
   input  wire logic [31:0] ee_rdata
);
   logic        busy;
   logic        next_busy;
   logic        done;
   logic        next_done;
   logic [31:0] rdata;
   logic [31:0] next_rdata;
   logic        next_ee_req;
   logic        next_ee_write;
   logic [7:0]  next_ee_addr;
   logic [31:0] next_ee_wdata;

   assign req.done  = done;
   assign req.rdata = rdata;

   // Holds the request to the engine until it reports completion
   always_comb begin
      next_busy     = busy;
      next_done     = 1'b0;
      next_rdata    = rdata;
      next_ee_req   = ee_req;
      next_ee_write = ee_write;
      next_ee_addr  = ee_addr;
      next_ee_wdata = ee_wdata;
      if (!busy && req.start) begin
         next_busy     = 1'b1;
         next_ee_req   = 1'b1;
         next_ee_write = req.write;
         next_ee_addr  = req.addr;
         next_ee_wdata = req.wdata;
      end else if (busy && ee_done) begin
         next_busy   = 1'b0;
         next_ee_req = 1'b0;
         next_done   = 1'b1;
         next_rdata  = ee_rdata;
      end
   end

   // Registers the request state
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         busy     <= 1'b0;
         done     <= 1'b0;
         rdata    <= cap_pkg::DATA_RESET;
         ee_req   <= 1'b0;
         ee_write <= 1'b0;
         ee_addr  <= cap_pkg::ADDR_RESET;
         ee_wdata <= cap_pkg::DATA_RESET;
      end else begin
         busy     <= next_busy;
         done     <= next_done;
         rdata    <= next_rdata;
         ee_req   <= next_ee_req;
         ee_write <= next_ee_write;
         ee_addr  <= next_ee_addr;
         ee_wdata <= next_ee_wdata;
      end
   end
endmodule

/* File: hw/hot_swap_and_vpd_capability.sv */
// Hot swap and product data capability items of the configuration space
`timescale 1ns/100ps
module hot_swap_and_vpd_capability (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic        cfg_wr,
   input  wire logic        cfg_rd,
   input  wire logic [7:0]  cfg_addr,
   input  wire logic [3:0]  cfg_be,
   input  wire logic [31:0] cfg_wdata,
   output      logic [31:0] cfg_rdata,
   output      logic        cfg_ack,
   input  wire logic        eeprom_load_done,
   input  wire logic        host_bus_disable_strap,
   input  wire logic        ejector_switch,
   input  wire logic        product_data_enable,
   output      logic        enumeration_signal,
   output      logic        hot_swap_led,
   output      logic        ee_req,
   output      logic        ee_write,
   output      logic [7:0]  ee_addr,
   output      logic [31:0] ee_wdata,
   input  wire logic        ee_done,
   input  wire logic [31:0] ee_rdata
);
   eeprom_if ee ();

   logic        sw_meta;
   logic        sw_sync;
   logic        load_meta;
   logic        load_sync;
   logic        load_prev;
   logic        insertion_pending;
   logic        extraction_pending;
   logic        blue_led_on;
   logic        enum_irq_mask;
   logic        product_data_flag;
   logic [7:0]  product_data_address;
   logic [31:0] product_data_word;
   logic        start;
   logic        write;
   logic        next_insertion_pending;
   logic        next_extraction_pending;
   logic        next_blue_led_on;
   logic        next_enum_irq_mask;
   logic        next_product_data_flag;
   logic [7:0]  next_product_data_address;
   logic [31:0] next_product_data_word;
   logic        next_start;
   logic        next_write;
   logic [31:0] next_cfg_rdata;
   logic [31:0] hs_word;
   logic [31:0] pd_word;
   logic        hs_wr;
   logic        pd_wr;
   logic        dt_wr;

   assign ee.start = start;
   assign ee.write = write;
   assign ee.addr  = product_data_address;
   assign ee.wdata = product_data_word;

   eeprom_port u_port (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .req      (ee),
      .ee_req   (ee_req),
      .ee_write (ee_write),
      .ee_addr  (ee_addr),
      .ee_wdata (ee_wdata),
      .ee_done  (ee_done),
      .ee_rdata (ee_rdata)
   );

   // Configuration write decode
   assign hs_wr = cfg_wr && cfg_addr == cap_pkg::HS_OFFSET;
   assign pd_wr = cfg_wr && cfg_addr == cap_pkg::PD_OFFSET;
   assign dt_wr = cfg_wr && cfg_addr == cap_pkg::DATA_OFFSET;

   // Read images of both items
   always_comb begin
      hs_word = 32'h0000_0000;
      hs_word[cap_pkg::INS_BIT]  = insertion_pending;
      hs_word[cap_pkg::EXT_BIT]  = extraction_pending;
      hs_word[cap_pkg::LED_BIT]  = blue_led_on;
      hs_word[cap_pkg::MASK_BIT] = enum_irq_mask;
      hs_word[15:8] = product_data_enable ? cap_pkg::HS_NEXT_PD
                                          : cap_pkg::NEXT_END;
      hs_word[7:0] = cap_pkg::HS_CAPABILITY_IDENTIFIER;
      pd_word = 32'h0000_0000;
      pd_word[cap_pkg::FLAG_BIT] = product_data_flag;
      pd_word[23:16] = product_data_address;
      pd_word[15:8] = cap_pkg::NEXT_END;
      pd_word[7:0] = cap_pkg::PD_CAPABILITY_IDENTIFIER;
   end

   // Register next values and read data
   always_comb begin
      next_insertion_pending    = insertion_pending;
      next_extraction_pending   = extraction_pending;
      next_blue_led_on          = blue_led_on;
      next_enum_irq_mask        = enum_irq_mask;
      next_product_data_flag    = product_data_flag;
      next_product_data_address = product_data_address;
      next_product_data_word    = product_data_word;
      next_start                = 1'b0;
      next_write                = write;
      next_cfg_rdata            = 32'h0000_0000;
      if (cfg_rd) begin
         case (cfg_addr)
            cap_pkg::HS_OFFSET:   next_cfg_rdata = hs_word;
            cap_pkg::PD_OFFSET:   next_cfg_rdata = pd_word;
            cap_pkg::DATA_OFFSET: next_cfg_rdata = product_data_word;
            default:              next_cfg_rdata = 32'h0000_0000;
         endcase
      end
      if (hs_wr && cfg_be[2]) begin
         if (cfg_wdata[cap_pkg::INS_BIT])
            next_insertion_pending = 1'b0;
         if (cfg_wdata[cap_pkg::EXT_BIT])
            next_extraction_pending = 1'b0;
         next_blue_led_on   = cfg_wdata[cap_pkg::LED_BIT];
         next_enum_irq_mask = cfg_wdata[cap_pkg::MASK_BIT];
      end
      if (load_sync && !load_prev && !host_bus_disable_strap)
         next_insertion_pending = 1'b1;
      if (sw_sync)
         next_extraction_pending = 1'b1;
      if (dt_wr) begin
         for (int i = 0; i < 4; i++) begin
            if (cfg_be[i])
               next_product_data_word[i*8 +: 8] = cfg_wdata[i*8 +: 8];
         end
      end
      if (pd_wr && cfg_be[2])
         next_product_data_address = cfg_wdata[23:16];
      if (pd_wr && cfg_be[3]) begin
         next_product_data_flag = cfg_wdata[cap_pkg::FLAG_BIT];
         next_write             = cfg_wdata[cap_pkg::FLAG_BIT];
         next_start             = 1'b1;
      end
      // read lands byte-ordered, low byte first
      if (ee.done && !write)
         next_product_data_word = ee.rdata;
      // write done clears flag, read done sets it
      if (ee.done)
         next_product_data_flag = !write;
   end

   // every field to default on reset
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sw_meta              <= 1'b0;
         sw_sync              <= 1'b0;
         load_meta            <= 1'b0;
         load_sync            <= 1'b0;
         load_prev            <= 1'b0;
         insertion_pending    <= 1'b0;
         extraction_pending   <= 1'b0;
         blue_led_on          <= 1'b0;
         enum_irq_mask        <= 1'b0;
         product_data_flag    <= 1'b0;
         product_data_address <= cap_pkg::ADDR_RESET;
         product_data_word    <= cap_pkg::DATA_RESET;
         start                <= 1'b0;
         write                <= 1'b0;
         cfg_rdata            <= 32'h0000_0000;
         cfg_ack              <= 1'b0;
         enumeration_signal   <= 1'b0;
         hot_swap_led         <= 1'b0;
      end else begin
         sw_meta              <= ejector_switch;
         sw_sync              <= sw_meta;
         load_meta            <= eeprom_load_done;
         load_sync            <= load_meta;
         load_prev            <= load_sync;
         insertion_pending    <= next_insertion_pending;
         extraction_pending   <= next_extraction_pending;
         blue_led_on          <= next_blue_led_on;
         enum_irq_mask        <= next_enum_irq_mask;
         product_data_flag    <= next_product_data_flag;
         product_data_address <= next_product_data_address;
         product_data_word    <= next_product_data_word;
         start                <= next_start;
         write                <= next_write;
         cfg_rdata            <= next_cfg_rdata;
         cfg_ack              <= cfg_rd | cfg_wr;
         enumeration_signal   <= (insertion_pending | extraction_pending)
                                 & ~enum_irq_mask;
         hot_swap_led         <= blue_led_on;
      end
   end

   // Enumeration follows pending bits and mask
   a_enum_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !$past(sys_rst) |-> enumeration_signal ==
      (($past(insertion_pending) | $past(extraction_pending))
       & !$past(enum_irq_mask)))
      else $error("enumeration does not follow pending and mask");
   a_mask_blocks: assert property (@(posedge ref_clk) disable iff (sys_rst)
      enum_irq_mask [*2] |-> !enumeration_signal)
      else $error("mask failed to block enumeration");
   a_led_follow: assert property (@(posedge ref_clk) disable iff (sys_rst)
      !$past(sys_rst) |-> hot_swap_led == $past(blue_led_on))
      else $error("led does not follow control bit");
   a_hs_ident: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg_rd && cfg_addr == cap_pkg::HS_OFFSET |=>
      cfg_rdata[7:0] == cap_pkg::HS_CAPABILITY_IDENTIFIER)
      else $error("hot swap identifier wrong");
   a_chain_link: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg_rd && cfg_addr == cap_pkg::HS_OFFSET |=> cfg_rdata[15:8] ==
      ($past(product_data_enable) ? cap_pkg::HS_NEXT_PD
                                  : cap_pkg::NEXT_END))
      else $error("hot swap next pointer wrong");
   a_pd_ident: assert property (@(posedge ref_clk) disable iff (sys_rst)
      cfg_rd && cfg_addr == cap_pkg::PD_OFFSET |=> cfg_rdata[15:0] ==
      {cap_pkg::NEXT_END, cap_pkg::PD_CAPABILITY_IDENTIFIER})
      else $error("product data pointer or identifier wrong");
   a_write_done: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ee.done && write |=> !product_data_flag)
      else $error("flag not cleared after write");
   a_read_done: assert property (@(posedge ref_clk) disable iff (sys_rst)
      ee.done && !write |=> product_data_flag
      && product_data_word == $past(ee.rdata))
      else $error("read completion wrong");
   a_ins_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
      load_sync && !load_prev && !host_bus_disable_strap |=> insertion_pending)
      else $error("insertion not set");
   a_ext_set: assert property (@(posedge ref_clk) disable iff (sys_rst)
      sw_sync |=> extraction_pending)
      else $error("extraction not set");
endmodule

/* File: tb/eeprom_model.sv */
// Behavioural serial EEPROM engine answering four-byte accesses
`timescale 1ns/100ps
module eeprom_model (
   input  wire logic        ref_clk,
   input  wire logic        slow,
   input  wire logic        ee_req,
   input  wire logic        ee_write,
   input  wire logic [7:0]  ee_addr,
   input  wire logic [31:0] ee_wdata,
   output      logic        ee_done,
   output      logic [31:0] ee_rdata
);
   logic [7:0] mem [256];
   int         cnt;
   logic       served;
   // Each byte starts out holding its own address
   initial begin
      for (int i = 0; i < 256; i++)
         mem[i] = i[7:0];
      ee_done = 1'b0;
      ee_rdata = 32'h0;
      served = 1'b0;
      cnt = 0;
   end
   // One done pulse per request, after a short or a long wait
   always @(posedge ref_clk) begin
      ee_done <= 1'b0;
      ee_rdata <= ~ee_rdata; // Stale read data never holds still
      if (!ee_req) begin
         served <= 1'b0;
         cnt <= 0;
      end else if (!served) begin
         cnt <= cnt + 1;
         if (cnt >= (slow ? 20 : 0)) begin
            ee_done <= 1'b1;
            served <= 1'b1;
            for (int i = 0; i < 4; i++)
               if (ee_write)
                  mem[ee_addr + 8'(i)] <= ee_wdata[8*i +: 8];
            ee_rdata <= {mem[ee_addr + 8'h3], mem[ee_addr + 8'h2],
                         mem[ee_addr + 8'h1], mem[ee_addr]};
         end
      end
   end
endmodule

/* File: tb/hot_swap_and_vpd_capability_tb_top.sv */
// Self-checking bench for the hot swap and product data registers
`timescale 1ns/100ps
module hot_swap_and_vpd_capability_tb_top;
   typedef struct {logic [7:0] addr; logic [31:0] exp;} row_s;
   logic        ref_clk = 1'b0, sys_rst = 1'b1, cfg_wr = 1'b0;
   logic        cfg_rd = 1'b0, load_done = 1'b0, strap = 1'b0;
   logic        eject = 1'b0, pd_en = 1'b1, slow = 1'b0;
   logic [7:0]  cfg_addr = 8'h00, ee_addr;
   logic [3:0]  cfg_be = 4'hf;
   logic [31:0] cfg_wdata = 32'h0, cfg_rdata, ee_wdata, ee_rdata, rd;
   logic        cfg_ack, enumeration_signal, hot_swap_led;
   logic        ee_req, ee_write, ee_done;
   int          fail_count = 0, num_checks = 0;
   row_s        rows [5] = '{'{8'he4, 32'h0000_e806},
      '{8'he8, 32'h0000_0003}, '{8'hec, 32'h0},
      '{8'h00, 32'h0}, '{8'hf0, 32'h0}};

   always #5 ref_clk = ~ref_clk;

   hot_swap_and_vpd_capability uut (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
      .eeprom_load_done(load_done), .host_bus_disable_strap(strap),
      .ejector_switch(eject), .product_data_enable(pd_en),
      .enumeration_signal(enumeration_signal),
      .hot_swap_led(hot_swap_led), .ee_req(ee_req),
      .ee_write(ee_write), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
      .ee_done(ee_done), .ee_rdata(ee_rdata));

   eeprom_model u_ee (.ref_clk(ref_clk), .slow(slow), .ee_req(ee_req),
      .ee_write(ee_write), .ee_addr(ee_addr), .ee_wdata(ee_wdata),
      .ee_done(ee_done), .ee_rdata(ee_rdata));

   // Compare and count
   task automatic chk(input string name, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Counts, verdict and end of run
   task automatic report_and_stop;
      $display("Checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // One config access, answer taken one cycle later
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [3:0] be, input logic [31:0] d);
      @(negedge ref_clk);
      cfg_wr = w;
      cfg_rd = !w;
      cfg_addr = a;
      cfg_be = be;
      cfg_wdata = d;
      @(negedge ref_clk);
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      rd = cfg_rdata;
      chk("cfg_ack", {31'h0, cfg_ack}, 32'h1);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      acc(1'b0, a, 4'hf, 32'h0);
      chk("cfg_rdata", rd, exp);
   endtask

   // Enumeration output after sync, pending and output registers
   task automatic enum_is(input logic exp);
      repeat (4) @(negedge ref_clk);
      chk("enumeration_signal", {31'h0, enumeration_signal}, {31'h0, exp});
   endtask

   // Poll the flag under a bound
   task automatic wait_flag(input logic want);
      for (int i = 0; i < 200; i++) begin
         acc(1'b0, 8'he8, 4'hf, 32'h0);
         if (rd[31] === want)
            return;
      end
      chk("product_data_flag", {31'h0, rd[31]}, {31'h0, want});
      report_and_stop;
   endtask

   initial begin
      repeat (2000) @(posedge ref_clk);
      chk("timeout", 32'h1, 32'h0);
      report_and_stop;
   end

   initial begin
      repeat (12) @(negedge ref_clk);
      sys_rst = 1'b0;
      foreach (rows[i])
         rdchk(rows[i].addr, rows[i].exp);
      pd_en = 1'b0;
      rdchk(8'he4, 32'h0000_0006);
      pd_en = 1'b1;
      $display("Test reset values done");
      acc(1'b1, 8'he4, 4'b0100, 32'h0008_0000);
      @(negedge ref_clk);
      chk("hot_swap_led", {31'h0, hot_swap_led}, 32'h1);
      rdchk(8'he4, 32'h0008_e806);
      acc(1'b1, 8'he4, 4'b0100, 32'h0);
      @(negedge ref_clk);
      chk("hot_swap_led", {31'h0, hot_swap_led}, 32'h0);
      $display("Test led done");
      strap = 1'b1;
      load_done = 1'b1;
      enum_is(1'b0);
      rdchk(8'he4, 32'h0000_e806);
      load_done = 1'b0;
      strap = 1'b0;
      enum_is(1'b0);
      load_done = 1'b1;
      enum_is(1'b1);
      rdchk(8'he4, 32'h0080_e806);
      acc(1'b1, 8'he4, 4'b0100, 32'h0002_0000);
      enum_is(1'b0);
      acc(1'b1, 8'he4, 4'b0100, 32'h0080_0000);
      rdchk(8'he4, 32'h0000_e806);
      $display("Test insertion done");
      acc(1'b1, 8'he4, 4'b0100, 32'h0);
      eject = 1'b1;
      enum_is(1'b1);
      eject = 1'b0;
      enum_is(1'b1);
      rdchk(8'he4, 32'h0040_e806);
      acc(1'b1, 8'he4, 4'b0100, 32'h0040_0000);
      enum_is(1'b0);
      $display("Test extraction done");
      // slow write of the data word
      acc(1'b1, 8'hec, 4'hf, 32'h4433_2211); // word before write
      slow = 1'b1;
      acc(1'b1, 8'he8, 4'b1100, 32'h8010_0000); // aligned address
      wait_flag(1'b0);
      chk("eeprom", {u_ee.mem[8'h13], u_ee.mem[8'h12], u_ee.mem[8'h11],
          u_ee.mem[8'h10]}, 32'h4433_2211);
      rdchk(8'he8, 32'h0010_0003);
      $display("Test product data write done");
      slow = 1'b0;
      acc(1'b1, 8'hec, 4'hf, 32'h0);
      acc(1'b1, 8'he8, 4'b1100, 32'h0020_0000); // aligned address
      wait_flag(1'b1);
      rdchk(8'hec, 32'h2322_2120);
      acc(1'b1, 8'he8, 4'b1100, 32'h0010_0000); // aligned address
      wait_flag(1'b1);
      rdchk(8'hec, 32'h4433_2211);
      $display("Test product data read done");
      acc(1'b1, 8'he4, 4'b0100, 32'h000a_0000);
      @(negedge ref_clk);
      chk("hot_swap_led", {31'h0, hot_swap_led}, 32'h1);
      sys_rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      sys_rst = 1'b0;
      chk("hot_swap_led", {31'h0, hot_swap_led}, 32'h0);
      rdchk(8'he4, 32'h0000_e806);
      rdchk(8'he8, 32'h0000_0003);
      rdchk(8'hec, 32'h0);
      // Load done still high, so insertion is announced again after reset
      enum_is(1'b1);
      $display("Test second reset done");
      report_and_stop;
   end
endmodule
